// ==== async_serial_receiver_addr_detect_test.sv ====
// Purpose: self-checking bench, transmitter facing receiver across the link
// Assumes: 10 MHz clock, classic Wishbone single cycles
// Notes:   fast baud (16 clocks a bit) except one slow word
`timescale 1ns/1ps
`default_nettype none
module async_serial_receiver_addr_detect_test;
   localparam logic [7:0]  AB = urx_pkg::OFS_BAUD;
   localparam logic [7:0]  AC = urx_pkg::OFS_CTRL;
   localparam logic [7:0]  AD = urx_pkg::OFS_DATA;
   localparam logic [7:0]  AS = urx_pkg::OFS_STAT;
   localparam logic [7:0]  AM = urx_pkg::OFS_MASK;
   localparam logic [31:0] ON = 32'h0000_0490;  // port, continuous rx, global irq
   logic        clk;
   logic        rst;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        ack;
   logic        irq;
   logic        irq_hp;
   logic [15:0] tx_div;
   logic        tx_nine;
   logic        tx_bad;
   logic [8:0]  tx_data;
   logic        tx_send;
   logic        tx_ready;
   logic [31:0] scratch;
   int          error_cnt;
   int          n_tests;

   urx_link_if u_urx_link_if ();
   urx_tx u_urx_tx (.CLK(clk), .RST(rst), .DIV(tx_div), .NINE(tx_nine), .BAD_STOP(tx_bad),
                    .DATA(tx_data), .SEND(tx_send), .READY(tx_ready), .LINK(u_urx_link_if));
   urx_rx u_urx_rx (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
                    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
                    .WB_ACK_O(ack), .IRQ(irq), .IRQ_HIGH_PRIO(irq_hp), .LINK(u_urx_link_if));
   urx_props u_urx_props (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
                    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
                    .WB_ACK_O(ack), .IRQ(irq), .IRQ_HIGH_PRIO(irq_hp),
                    .serial_rx_pin(u_urx_link_if.serial_rx_pin));

   always #50 clk = ~clk;

   // ****************************************
   // tasks
   // ****************************************
   task automatic summarize();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %08h expected %08h", $time, got, exp);
      end
   endtask
   // ack sampled at the edge itself; a hang is left to the watchdog
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= 4'hF;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, scratch);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic irqc(input logic e);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, {31'h0, e});
   endtask
   task automatic send(input logic [8:0] w, input logic nine, input logic bad);
      @(posedge clk);
      tx_data <= w;
      tx_nine <= nine;
      tx_bad  <= bad;
      tx_send <= 1'b1;
      @(posedge clk);
      tx_send <= 1'b0;
      do @(posedge clk); while (tx_ready !== 1'b1);
      repeat (4) @(posedge clk);
   endtask

   // ****************************************
   // watchdog
   // ****************************************
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      summarize();
   end

   // ****************************************
   // tests
   // ****************************************
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0;
      tx_div = 16'h0010;
      tx_nine = 1'b0;
      tx_bad = 1'b0;
      tx_data = 9'h000;
      tx_send = 1'b0;
      error_cnt = 0;
      n_tests = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rdc(AC, 32'h0);
      rdc(AS, 32'h0);
      rdc(AD, 32'h0);
      wr(8'h14, 32'hFFFF_FFFF);
      rdc(8'h14, 32'h0);
      wr(AB, 32'h0000_0100);
      rdc(AB, 32'h0000_0100);
      wr(AM, 32'h7);
      wr(AC, ON);
      send(9'h0A5, 1'b0, 1'b0);
      irqc(1'b1);
      rdc(AS, 32'h1);
      rdc(AC, ON | 32'h200);
      rdc(AD, 32'hA5);
      rdc(AC, ON);
      wr(AC, ON | 32'h800);
      irqc(1'b1);
      chk({31'h0, irq_hp}, 32'h1);
      wr(AS, 32'h1);
      irqc(1'b0);
      wr(AM, 32'h0);
      send(9'h03C, 1'b0, 1'b0);
      irqc(1'b0);
      rdc(AS, 32'h1);
      wr(AM, 32'h1);
      irqc(1'b1);
      wr(AC, 32'h090);
      irqc(1'b0);
      wr(AC, ON);
      irqc(1'b1);
      rdc(AD, 32'h3C);
      wr(AS, 32'h7);
      send(9'h05A, 1'b0, 1'b1);
      rdc(AS, 32'h3);
      rdc(AC, ON | 32'h204);
      rdc(AD, 32'h5A);
      wr(AC, 32'h480);
      rdc(AC, 32'h480);
      wr(AS, 32'h7);
      wr(AC, ON);
      send(9'h011, 1'b0, 1'b0);
      send(9'h022, 1'b0, 1'b0);
      rdc(AS, 32'h5);
      rdc(AC, ON | 32'h202);
      wr(AS, 32'h7);
      send(9'h033, 1'b0, 1'b0);
      rdc(AS, 32'h0);
      wb(1'b0, AD, 32'h0, scratch);
      wr(AC, 32'h480);
      wr(AC, ON);
      rdc(AC, ON);
      send(9'h044, 1'b0, 1'b0);
      rdc(AD, 32'h44);
      wr(AS, 32'h7);
      wr(AC, ON | 32'h40);
      send(9'h13C, 1'b1, 1'b0);
      rdc(AC, ON | 32'h241);
      rdc(AD, 32'h3C);
      wr(AS, 32'h7);
      wr(AC, ON | 32'h48);
      send(9'h055, 1'b1, 1'b0);
      rdc(AS, 32'h0);
      rdc(AC, ON | 32'h49);
      send(9'h1AA, 1'b1, 1'b0);
      rdc(AS, 32'h1);
      rdc(AD, 32'hAA);
      wr(AS, 32'h7);
      wr(AC, ON | 32'h40);
      send(9'h066, 1'b1, 1'b0);
      rdc(AS, 32'h1);
      rdc(AD, 32'h66);
      wr(AS, 32'h7);
      wr(AC, 32'h480);
      send(9'h077, 1'b0, 1'b0);
      rdc(AS, 32'h0);
      wr(AC, ON | 32'h100);
      send(9'h078, 1'b0, 1'b0);
      rdc(AS, 32'h0);
      wr(AB, 32'h0);
      tx_div <= 16'h0040;
      wr(AC, ON);
      send(9'h0C3, 1'b0, 1'b0);
      rdc(AS, 32'h1);
      rdc(AD, 32'hC3);
      summarize();
   end
endmodule
`default_nettype wire

// ==== urx_link_if.sv ====
// Purpose: serial line between the remote transmitter and the receiver
// Assumes: line idles high; one driver, the far end
// Notes:   both ends share the system clock
`timescale 1ns/1ps
`default_nettype none
interface urx_link_if;
   logic serial_rx_pin;

   modport dev_mp (input serial_rx_pin);
   modport far_mp (output serial_rx_pin);
endinterface
`default_nettype wire

// ==== urx_pkg.sv ====
// Purpose: shared constants and types of the serial receiver and its far-end transmitter
// Assumes: 10 MHz system clock, word-aligned classic Wishbone register access
// Notes:   byte offsets, field positions, reset values and state codes live here only
package urx_pkg;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_BAUD = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_MASK = 8'h10;

   // ****************************************
   // field positions
   // ****************************************
   localparam int unsigned BAUD_HS_BIT    = 8;
   localparam int unsigned CTL_NINTH_BIT  = 0;
   localparam int unsigned CTL_OERR_BIT   = 1;
   localparam int unsigned CTL_FERR_BIT   = 2;
   localparam int unsigned CTL_ADDRESS_DETECT_ENABLE_BIT  = 3;
   localparam int unsigned CTL_CONTINUOUS_RX_ENABLE_BIT   = 4;
   localparam int unsigned CTL_RX9_BIT    = 6;
   localparam int unsigned CTL_SERIAL_PORT_ENABLE_BIT   = 7;
   localparam int unsigned CTL_SYNC_BIT   = 8;
   localparam int unsigned CTL_FULL_BIT   = 9;
   localparam int unsigned CTL_GIE_BIT    = 10;
   localparam int unsigned CTL_PRIO_BIT   = 11;
   localparam int unsigned EV_DONE_BIT    = 0;
   localparam int unsigned EV_FERR_BIT    = 1;
   localparam int unsigned EV_OERR_BIT    = 2;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] RST_DIVISOR = 8'h00;
   localparam logic [2:0] RST_MASK    = 3'h0;

   // ****************************************
   // timing
   // ****************************************
   localparam logic [3:0] SAMPLE_PHASE = 4'h9;
   localparam logic [3:0] LAST_BIT_8   = 4'h7;
   localparam logic [3:0] LAST_BIT_9   = 4'h8;
   localparam logic [3:0] FRAME_LEN_8  = 4'hA;
   localparam logic [3:0] FRAME_LEN_9  = 4'hB;

   typedef enum logic [3:0] {
      URX_IDLE  = 4'h1,
      URX_START = 4'h2,
      URX_DATA  = 4'h4,
      URX_STOP  = 4'h8
   } urx_state_t;

endpackage

// ==== urx_props.sv ====
// Purpose: bus and interrupt properties of the serial receiver
// Assumes: one clock domain, synchronous active-high reset
// Notes:   shadows of control bits follow accepted writes on the accepting edge
`timescale 1ns/1ps
`default_nettype none
module urx_props (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   input  wire logic [31:0] WB_DAT_O,
   input  wire logic        WB_ACK_O,
   input  wire logic        IRQ,
   input  wire logic        IRQ_HIGH_PRIO,
   input  wire logic        serial_rx_pin
);
   logic       wr_ok;
   logic       mapped;
   logic       gie_q;
   logic       prio_q;
   logic [2:0] mask_q;

   // same edge as the design's register update, so no slack is needed
   assign wr_ok  = !WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0];
   assign mapped = WB_ADR_I inside {urx_pkg::OFS_BAUD, urx_pkg::OFS_CTRL, urx_pkg::OFS_DATA,
                                    urx_pkg::OFS_STAT, urx_pkg::OFS_MASK};

   // ****************************************
   // shadows (taken at the accepting edge)
   // ****************************************
   always_ff @(posedge CLK) begin
      if (RST) begin
         gie_q  <= 1'b0;
         prio_q <= 1'b0;
         mask_q <= 3'h0;
      end else begin
         if (wr_ok && WB_SEL_I[1] && WB_ADR_I == urx_pkg::OFS_CTRL) begin
            gie_q  <= WB_DAT_I[urx_pkg::CTL_GIE_BIT];
            prio_q <= WB_DAT_I[urx_pkg::CTL_PRIO_BIT];
         end
         if (wr_ok && WB_SEL_I[0] && WB_ADR_I == urx_pkg::OFS_MASK) begin
            mask_q <= WB_DAT_I[2:0];
         end
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // ****************************************
   // properties
   // ****************************************
   property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_next; (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
   property p_ack_cause; WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_dat_idle; !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   property p_data_width;
      (WB_ACK_O && !WB_WE_I && WB_ADR_I == urx_pkg::OFS_DATA) |-> WB_DAT_O[31:8] == 24'h0;
   endproperty
   a_data_width: assert property (p_data_width) else $error("data wider than a byte");
   property p_unmapped; (WB_ACK_O && !WB_WE_I && !mapped) |-> WB_DAT_O == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_prio; IRQ_HIGH_PRIO == prio_q; endproperty
   a_prio: assert property (p_prio) else $error("priority output off control bit");
   property p_gie; !gie_q |-> !IRQ; endproperty
   a_gie: assert property (p_gie) else $error("irq with global enable off");
   property p_mask; (mask_q == 3'h0) |-> !IRQ; endproperty
   a_mask: assert property (p_mask) else $error("irq with all events masked");
   c_start: cover property ($fell(serial_rx_pin));
endmodule
`default_nettype wire

// ==== urx_rx.sv ====
// Purpose: asynchronous serial receiver with address detect, Wishbone registers
// Assumes: receive line synchronous to CLK; software keeps its own duties
// Notes:   x16 oversampling, 3-sample majority at phases 7..9 of each bit
//
// Notes on behaviour
// - receive pin feeds the data recovery stage
// - recovery samples line at sixteen times baud
// - main shifter advances once per bit period
// - software loads divisor and speed before enabling
// - async needs clocked-mode clear, port enable set
// - nine-bit select gives nine-bit words
// - words received only while continuous enable set
// - completion sets flag, interrupts if enabled
// - status shows ninth bit and word errors
// - low eight bits read from data register
// - clearing continuous enable clears error state
// - address-detect with nine-bit mode for multidrop
// - interrupt needs receive and global enables; overrun and framing events interrupt through mask bits 2 and 1 without bit 0
// - priority bit routes interrupt high or low
// - software reads word to check addressing
// - address-detect off passes every word
`timescale 1ns/1ps
`default_nettype none
module urx_rx (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic [31:0]      WB_DAT_O,
   output logic             WB_ACK_O,
   output logic             IRQ,
   output logic             IRQ_HIGH_PRIO,
   urx_link_if.dev_mp       LINK
);

   typedef struct packed {
      urx_pkg::urx_state_t st;
      logic [3:0]          ph;
      logic [3:0]          bitn;
      logic [8:0]          sh;
      logic [1:0]          samp;
      logic [9:0]          bcnt;
      logic [7:0]          div;
      logic                hs;
      logic                sync;
      logic                serial_port_enable;
      logic                rx9;
      logic                continuous_rx_enable;
      logic                address_detect_enable;
      logic                global_irq_enable;
      logic                prio;
      logic [7:0]          data;
      logic                ninth;
      logic                ferr;
      logic                oerr;
      logic                full;
      logic [2:0]          ev;
      logic [2:0]          mask;
      logic                ack;
      logic [31:0]         rdat;
      logic                irq;
   } urx_rx_t;

   urx_rx_t     q;
   urx_rx_t     d;
   logic        line;
   logic        run;
   logic        tick;
   logic        bitv;
   logic        done;
   logic        acc;
   logic        wr;
   logic        rd_data;
   logic        full_now;
   logic [9:0]  reload;
   logic [7:0]  w_data;
   logic        w_ninth;
   logic [2:0]  ev_set;
   logic [2:0]  ev_clr;

   function automatic logic maj3(input logic [2:0] s);
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   assign line = LINK.serial_rx_pin;

   always_comb begin
      d        = q;
      acc      = WB_CYC_I & WB_STB_I & ~q.ack;
      wr       = acc & WB_WE_I & WB_SEL_I[0];
      rd_data  = acc & ~WB_WE_I & (WB_ADR_I == urx_pkg::OFS_DATA);
      run      = q.serial_port_enable & ~q.sync & q.continuous_rx_enable;
      reload   = q.hs ? {2'b00, q.div} : {q.div, 2'b11};
      tick     = (q.bcnt == 10'h000);
      bitv     = maj3({q.samp, line});
      done     = 1'b0;
      ev_set   = 3'h0;
      ev_clr   = 3'h0;
      w_data   = q.rx9 ? q.sh[7:0] : q.sh[8:1];
      w_ninth  = q.rx9 & q.sh[8];
      full_now = q.full & ~rd_data;                   // a read in the same cycle frees room

      // ****************************************
      // oversampling clock and bit recovery
      // ****************************************
      // low speed divides by four more: 64 clocks per divisor step per bit
      if (!run || tick) begin
         d.bcnt = reload;
      end else begin
         d.bcnt = q.bcnt - 10'h001;
      end

      if (run && tick) begin
         d.samp = {q.samp[0], line};
         unique case (q.st)
            urx_pkg::URX_IDLE: begin
               // halted after an overrun until reception is re-enabled
               if (!line && !q.oerr) begin
                  d.st = urx_pkg::URX_START;
                  d.ph = 4'h0;
               end
            end
            urx_pkg::URX_START: begin
               d.ph = q.ph + 4'h1;
               if (q.ph == urx_pkg::SAMPLE_PHASE) begin
                  // glitch shorter than half a bit is rejected
                  d.st   = bitv ? urx_pkg::URX_IDLE : urx_pkg::URX_DATA;
                  d.bitn = 4'h0;
               end
            end
            urx_pkg::URX_DATA: begin
               d.ph = q.ph + 4'h1;
               if (q.ph == urx_pkg::SAMPLE_PHASE) begin
                  d.sh   = {bitv, q.sh[8:1]};
                  d.bitn = q.bitn + 4'h1;
                  if (q.bitn == (q.rx9 ? urx_pkg::LAST_BIT_9 : urx_pkg::LAST_BIT_8)) begin
                     d.st = urx_pkg::URX_STOP;
                  end
               end
            end
            urx_pkg::URX_STOP: begin
               d.ph = q.ph + 4'h1;
               if (q.ph == urx_pkg::SAMPLE_PHASE) begin
                  done = 1'b1;
                  d.st = urx_pkg::URX_IDLE;
               end
            end
         endcase
      end
      if (!run) begin
         d.st = urx_pkg::URX_IDLE;
         d.ph = 4'h0;
      end

      // ****************************************
      // word completion
      // ****************************************
      if (rd_data) begin
         d.full = 1'b0;
      end
      if (done) begin
         if (q.address_detect_enable && q.rx9 && !w_ninth) begin
            d.full = full_now;
         end else if (full_now) begin
            d.oerr = 1'b1;
            ev_set[urx_pkg::EV_OERR_BIT] = 1'b1;
         end else begin
            d.data  = w_data;
            d.ninth = w_ninth;
            d.ferr  = ~bitv;
            d.full  = 1'b1;
            ev_set[urx_pkg::EV_DONE_BIT] = 1'b1;
            ev_set[urx_pkg::EV_FERR_BIT] = ~bitv;
         end
      end

      // ****************************************
      // register writes
      // ****************************************
      if (wr) begin
         unique case (WB_ADR_I)
            urx_pkg::OFS_BAUD: begin
               d.div = WB_DAT_I[7:0];
               if (WB_SEL_I[1]) begin
                  d.hs = WB_DAT_I[urx_pkg::BAUD_HS_BIT];
               end
            end
            urx_pkg::OFS_CTRL: begin
               d.address_detect_enable = WB_DAT_I[urx_pkg::CTL_ADDRESS_DETECT_ENABLE_BIT];
               d.continuous_rx_enable  = WB_DAT_I[urx_pkg::CTL_CONTINUOUS_RX_ENABLE_BIT];
               d.rx9   = WB_DAT_I[urx_pkg::CTL_RX9_BIT];
               d.serial_port_enable  = WB_DAT_I[urx_pkg::CTL_SERIAL_PORT_ENABLE_BIT];
               if (WB_SEL_I[1]) begin
                  d.sync = WB_DAT_I[urx_pkg::CTL_SYNC_BIT];
                  d.global_irq_enable  = WB_DAT_I[urx_pkg::CTL_GIE_BIT];
                  d.prio = WB_DAT_I[urx_pkg::CTL_PRIO_BIT];
               end
            end
            urx_pkg::OFS_STAT: ev_clr = WB_DAT_I[2:0];
            urx_pkg::OFS_MASK: d.mask = WB_DAT_I[2:0];
            default: ;
         endcase
      end
      if (!d.continuous_rx_enable) begin
         d.oerr = 1'b0;
         d.ferr = 1'b0;
      end
      d.ev  = (q.ev & ~ev_clr) | ev_set;              // set wins over clear
      // mask bit 0 is the receive interrupt enable
      d.irq = d.global_irq_enable & |(d.ev & d.mask);

      // ****************************************
      // bus answer
      // ****************************************
      d.ack  = acc;
      d.rdat = 32'h0000_0000;
      if (acc && !WB_WE_I) begin
         unique case (WB_ADR_I)
            urx_pkg::OFS_BAUD: d.rdat = {23'h0, q.hs, q.div};
            urx_pkg::OFS_CTRL: d.rdat = {20'h00000, q.prio, q.global_irq_enable, q.full, q.sync,
                                         q.serial_port_enable, q.rx9, 1'b0, q.continuous_rx_enable, q.address_detect_enable,
                                         q.ferr, q.oerr, q.ninth};
            urx_pkg::OFS_DATA: d.rdat = {24'h000000, q.data};
            urx_pkg::OFS_STAT: d.rdat = {29'h0, q.ev};
            urx_pkg::OFS_MASK: d.rdat = {29'h0, q.mask};
            default:           d.rdat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         q       <= '0;
         q.st    <= urx_pkg::URX_IDLE;
         q.div   <= urx_pkg::RST_DIVISOR;
         q.mask  <= urx_pkg::RST_MASK;
         q.samp  <= 2'h3;
      end else begin
         q <= d;
      end
   end

   assign WB_DAT_O      = q.rdat;
   assign WB_ACK_O      = q.ack;
   assign IRQ           = q.irq;
   assign IRQ_HIGH_PRIO = q.prio;

endmodule
`default_nettype wire

// ==== urx_tx.sv ====
// Purpose: remote asynchronous transmitter driving the receive line
// Assumes: DIV gives system clocks per bit, stable while busy
// Notes:   BAD_STOP forces a low stop bit to provoke framing errors
`timescale 1ns/1ps
`default_nettype none
module urx_tx (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic [15:0] DIV,
   input  wire logic        NINE,
   input  wire logic        BAD_STOP,
   input  wire logic [8:0]  DATA,
   input  wire logic        SEND,
   output logic             READY,
   urx_link_if.far_mp       LINK
);

   typedef struct packed {
      urx_pkg::urx_state_t st;
      logic [15:0]         cnt;
      logic [3:0]          left;
      logic [10:0]         fr;
      logic                line;
      logic                ready;
   } urx_tx_t;

   urx_tx_t q;
   urx_tx_t d;
   logic    stop_v;

   // ****************************************
   // frame sequencer
   // ****************************************
   always_comb begin
      d      = q;
      stop_v = ~BAD_STOP;
      unique case (q.st)
         urx_pkg::URX_IDLE: begin
            if (SEND) begin
               // start bit first, lsb first, then stop
               d.fr    = NINE ? {stop_v, DATA, 1'b0} : {1'b1, stop_v, DATA[7:0], 1'b0};
               d.left  = NINE ? urx_pkg::FRAME_LEN_9 : urx_pkg::FRAME_LEN_8;
               d.cnt   = DIV;
               d.st    = urx_pkg::URX_DATA;
               d.ready = 1'b0;
               d.line  = 1'b0;
            end
         end
         default: begin
            if (q.cnt <= 16'h0001) begin
               d.cnt  = DIV;
               d.fr   = {1'b1, q.fr[10:1]};
               d.left = q.left - 4'h1;
               d.line = (q.left == 4'h1) ? 1'b1 : q.fr[1];
               if (q.left == 4'h1) begin
                  d.st    = urx_pkg::URX_IDLE;
                  d.ready = 1'b1;
               end
            end else begin
               d.cnt = q.cnt - 16'h0001;
            end
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         q.st    <= urx_pkg::URX_IDLE;
         q.cnt   <= 16'h0000;
         q.left  <= 4'h0;
         q.fr    <= 11'h7FF;
         q.line  <= 1'b1;
         q.ready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign READY              = q.ready;
   assign LINK.serial_rx_pin = q.line;

endmodule
`default_nettype wire
